/* status_pkg.sv */
// shared constants for the algorithm status word and its command link
package status_pkg;

	// ****************************************************************
	// status word layout
	// ****************************************************************
	localparam int          STATUS_W          = 16;
	localparam int          BIT_CRC_SUSP      = 8;
	localparam int          BIT_READY         = 7;
	localparam int          BIT_ERASE_SUSP    = 6;
	localparam int          BIT_ERASE_FAIL    = 5;
	localparam int          BIT_PROG_FAIL     = 4;
	localparam int          BIT_BUF_ABORT     = 3;
	localparam int          BIT_PROG_SUSP     = 2;
	localparam int          BIT_LOCK_ERR      = 1;
	localparam int          BIT_ERASE_CHECK   = 0;
	localparam logic [15:0] STATUS_RESET      = 16'h0080;
	localparam logic [15:0] RESULT_MASK       = 16'h003b;
	localparam logic [15:0] RESERVED_MASK     = 16'hfe00;
	localparam logic [15:0] VALID_WHEN_READY  = 16'h017f;
	localparam logic [6:0]  NOISE_SEED        = 7'h55;

	// ****************************************************************
	// link widths and commands
	// ****************************************************************
	localparam int          ADDR_W            = 24;
	localparam int          DATA_W            = 16;
	localparam int          CMD_W             = 4;

	typedef enum logic [3:0] {
		CMD_NONE,
		CMD_STATUS_READ,
		CMD_CLEAR_STATUS,
		CMD_SOFT_RESET,
		CMD_ERASE_RESUME,
		CMD_PROG_RESUME
	} cmd_e;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// host-side view: drop reserved bits, and bits invalid while busy
	function automatic logic [15:0] usable_status(input logic [15:0] raw);
		logic [15:0] m;
		m = raw & ~RESERVED_MASK;
		if (!m[BIT_READY]) begin
			m = m & ~VALID_WHEN_READY;
		end
		return m;
	endfunction

endpackage

/* flash_link_if.sv */
// link between host controller and status logic of the flash device
`timescale 1ns/1ns
interface flash_link_if;
	import status_pkg::*;
	logic              cmd_valid;
	logic [CMD_W-1:0]  cmd_code;
	logic              rd_valid;
	logic [ADDR_W-1:0] rd_addr;
	logic              rd_done;
	logic [DATA_W-1:0] rd_data;
	logic              rd_was_status;

	modport device (
		input  cmd_valid,
		input  cmd_code,
		input  rd_valid,
		input  rd_addr,
		output rd_done,
		output rd_data,
		output rd_was_status
	);
	modport host (
		output cmd_valid,
		output cmd_code,
		output rd_valid,
		output rd_addr,
		input  rd_done,
		input  rd_data,
		input  rd_was_status
	);
endinterface

/* status_word.sv */
// sticky status word with result and state bits of the embedded algorithm
`timescale 1ns/1ns
module status_word
	import status_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        clear_results,
	input  wire logic        erase_resume,
	input  wire logic        prog_resume,
	input  wire logic        alg_start,
	input  wire logic        alg_done,
	input  wire logic        erase_done,
	input  wire logic        erase_failed,
	input  wire logic        prog_done,
	input  wire logic        prog_failed,
	input  wire logic        prog_to_susp_sector,
	input  wire logic        buf_abort,
	input  wire logic        lock_hit,
	input  wire logic        check_done,
	input  wire logic        check_ok,
	input  wire logic        erase_suspend,
	input  wire logic        prog_suspend,
	input  wire logic        crc_suspend,
	input  wire logic        crc_resume,
	output logic [15:0]      status_q
);

	logic [15:0] status_d;
	logic [6:0]  noise_q;
	logic [6:0]  noise_d;

	// ****************************************************************
	// next state: clear first, so a same-cycle event still sets
	// ****************************************************************
	always_comb begin
		status_d = status_q;
		noise_d  = {noise_q[5:0], noise_q[6] ^ noise_q[5]};
		if (clear_results) begin
			status_d = status_d & ~RESULT_MASK;
		end
		if (alg_start) begin
			status_d[BIT_READY] = 1'b0;
		end
		if (alg_done) begin
			status_d[BIT_READY] = 1'b1;
		end
		if (erase_done) begin
			// suspended program or erase forces failure
			status_d[BIT_ERASE_FAIL] = erase_failed | status_q[BIT_ERASE_SUSP]
				| status_q[BIT_PROG_SUSP];
		end
		if (prog_done) begin
			status_d[BIT_PROG_FAIL] = prog_failed | status_q[BIT_PROG_SUSP]
				| (status_q[BIT_ERASE_SUSP] & prog_to_susp_sector);
		end
		if (prog_done | erase_done) begin
			status_d[BIT_LOCK_ERR] = lock_hit;
		end
		if (buf_abort) begin
			status_d[BIT_BUF_ABORT] = 1'b1;
		end
		if (check_done) begin
			status_d[BIT_ERASE_CHECK] = check_ok;
		end
		if (erase_suspend) begin
			status_d[BIT_ERASE_SUSP] = 1'b1;
		end
		if (erase_resume) begin
			status_d[BIT_ERASE_SUSP] = 1'b0;
		end
		if (prog_suspend) begin
			status_d[BIT_PROG_SUSP] = 1'b1;
		end
		if (prog_resume) begin
			status_d[BIT_PROG_SUSP] = 1'b0;
		end
		if (crc_suspend) begin
			status_d[BIT_CRC_SUSP] = 1'b1;
		end
		if (crc_resume) begin
			status_d[BIT_CRC_SUSP] = 1'b0;
		end
		// reserved bits wander so hosts learn to mask them
		status_d[15:9] = noise_q;
	end

	// register stage
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			status_q <= STATUS_RESET;
			noise_q  <= NOISE_SEED;
		end else begin
			status_q <= status_d;
			noise_q  <= noise_d;
		end
	end

endmodule

/* flash_status_device.sv */
// device end: command decode and one-shot status overlay on reads
`timescale 1ns/1ns
module flash_status_device
	import status_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	flash_link_if.device     link,
	input  wire logic        alg_start,
	input  wire logic        alg_done,
	input  wire logic        erase_done,
	input  wire logic        erase_failed,
	input  wire logic        prog_done,
	input  wire logic        prog_failed,
	input  wire logic        prog_to_susp_sector,
	input  wire logic        buf_abort,
	input  wire logic        lock_hit,
	input  wire logic        check_done,
	input  wire logic        check_ok,
	input  wire logic        erase_suspend,
	input  wire logic        prog_suspend,
	input  wire logic        crc_suspend,
	input  wire logic        crc_resume,
	input  wire logic [15:0] array_data,
	output logic [15:0]      status_now,
	output logic             soft_reset_pulse
);

	typedef enum logic {ARRAY_MODE, OVERLAY_MODE} mode_e;

	// ****************************************************************
	// state and decode signals
	// ****************************************************************
	mode_e       mode_q;
	mode_e       mode_d;
	logic        done_q;
	logic        done_d;
	logic [15:0] data_q;
	logic [15:0] data_d;
	logic        was_st_q;
	logic        was_st_d;
	logic        srst_q;
	logic        srst_d;
	logic        cmd_clear;
	logic        cmd_eres;
	logic        cmd_pres;
	logic        cmd_stat;
	logic        cmd_srst;
	logic [15:0] status_q;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// one command strobe for one code; unknown codes match nothing
	function automatic logic cmd_is(
		input logic             valid,
		input logic [CMD_W-1:0] code,
		input cmd_e             want
	);
		return valid & (code == want);
	endfunction

	// word handed back for a read: status while the overlay is armed
	function automatic logic [15:0] read_word(
		input mode_e       mode,
		input logic [15:0] word,
		input logic [15:0] array_word
	);
		logic [15:0] w;
		w = array_word;
		if (mode == OVERLAY_MODE) begin
			w = word;
		end
		return w;
	endfunction

	// ****************************************************************
	// command decode
	// ****************************************************************
	// clear-status and soft reset share the result clear; state bits are
	// left alone so a suspended operation survives the clear, and codes
	// outside the set are simply ignored
	assign cmd_clear = cmd_is(link.cmd_valid, link.cmd_code, CMD_CLEAR_STATUS)
		| cmd_is(link.cmd_valid, link.cmd_code, CMD_SOFT_RESET);
	assign cmd_eres  = cmd_is(link.cmd_valid, link.cmd_code, CMD_ERASE_RESUME);
	assign cmd_pres  = cmd_is(link.cmd_valid, link.cmd_code, CMD_PROG_RESUME);
	assign cmd_stat  = cmd_is(link.cmd_valid, link.cmd_code, CMD_STATUS_READ);
	assign cmd_srst  = cmd_is(link.cmd_valid, link.cmd_code, CMD_SOFT_RESET);

	// ****************************************************************
	// status word
	// ****************************************************************
	// the word lives in its own module, so the sticky-bit priorities
	// stay in one place
	status_word status_word_inst (
		.clk_sys             (clk_sys),
		.resetn              (resetn),
		.clear_results       (cmd_clear),
		.erase_resume        (cmd_eres),
		.prog_resume         (cmd_pres),
		.alg_start           (alg_start),
		.alg_done            (alg_done),
		.erase_done          (erase_done),
		.erase_failed        (erase_failed),
		.prog_done           (prog_done),
		.prog_failed         (prog_failed),
		.prog_to_susp_sector (prog_to_susp_sector),
		.buf_abort           (buf_abort),
		.lock_hit            (lock_hit),
		.check_done          (check_done),
		.check_ok            (check_ok),
		.erase_suspend       (erase_suspend),
		.prog_suspend        (prog_suspend),
		.crc_suspend         (crc_suspend),
		.crc_resume          (crc_resume),
		.status_q            (status_q)
	);

	// ****************************************************************
	// soft reset strobe
	// ****************************************************************
	// one-cycle pulse for the sequencer, which must abandon its work;
	// the result bits are already cleared through cmd_clear
	always_comb begin
		srst_d = cmd_srst;
	end

	// register stage
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			srst_q <= 1'b0;
		end else begin
			srst_q <= srst_d;
		end
	end

	// ****************************************************************
	// overlay mode and read answer
	// ****************************************************************
	// a read in the same cycle as the command still sees the array; the
	// overlay then waits for the following read, whatever its address
	always_comb begin
		mode_d   = mode_q;
		done_d   = 1'b0;
		data_d   = data_q;
		was_st_d = was_st_q;
		if (link.rd_valid) begin
			done_d = 1'b1;
			data_d = read_word(mode_q, status_q, array_data);
			case (mode_q)
				OVERLAY_MODE: begin
					was_st_d = 1'b1;
					mode_d   = ARRAY_MODE;
				end
				default: begin
					was_st_d = 1'b0;
				end
			endcase
		end
		if (cmd_stat) begin
			mode_d = OVERLAY_MODE;
		end
	end

	// register stage; read data holds until the next read replaces it
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_q   <= ARRAY_MODE;
			done_q   <= 1'b0;
			data_q   <= 16'h0000;
			was_st_q <= 1'b0;
		end else begin
			mode_q   <= mode_d;
			done_q   <= done_d;
			data_q   <= data_d;
			was_st_q <= was_st_d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// the status word is also offered raw, reserved noise included
	assign status_now       = status_q;
	assign soft_reset_pulse = srst_q;

	// read answer, all straight from flip-flops
	assign link.rd_done       = done_q;
	assign link.rd_data       = data_q;
	assign link.rd_was_status = was_st_q;

endmodule

/* flash_status_host.sv */
// host end: issues status read and polls until the device is ready
`timescale 1ns/1ns
module flash_status_host
	import status_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	flash_link_if.host       link,
	input  wire logic        poll_start,
	input  wire logic        clear_req,
	output logic             poll_busy,
	output logic             poll_done,
	output logic [15:0]      status_out
);

	typedef enum logic [1:0] {IDLE, SEND_CMD, SEND_RD, WAIT_RD} hstate_e;

	hstate_e     state_q;
	hstate_e     state_d;
	logic [15:0] stat_q;
	logic [15:0] stat_d;
	logic        done_q;
	logic        done_d;
	logic        cmd_v;
	logic [3:0]  cmd_c;

	// ****************************************************************
	// poll machine: repeat until ready, since suspend bits lag
	// ****************************************************************
	always_comb begin
		state_d = state_q;
		stat_d  = stat_q;
		done_d  = 1'b0;
		cmd_v   = 1'b0;
		cmd_c   = CMD_NONE;
		case (state_q)
			IDLE: begin
				if (clear_req) begin
					cmd_v = 1'b1;
					cmd_c = CMD_CLEAR_STATUS;
				end else if (poll_start) begin
					state_d = SEND_CMD;
				end
			end
			SEND_CMD: begin
				cmd_v   = 1'b1;
				cmd_c   = CMD_STATUS_READ;
				state_d = SEND_RD;
			end
			SEND_RD: begin
				state_d = WAIT_RD;
			end
			WAIT_RD: begin
				if (link.rd_done) begin
					stat_d = usable_status(link.rd_data);
					if (link.rd_data[BIT_READY]) begin
						state_d = IDLE;
						done_d  = 1'b1;
					end else begin
						state_d = SEND_CMD;
					end
				end
			end
			default: state_d = IDLE;
		endcase
	end

	// register stage
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= IDLE;
			stat_q  <= 16'h0000;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			stat_q  <= stat_d;
			done_q  <= done_d;
		end
	end

	assign link.cmd_valid = cmd_v;
	assign link.cmd_code  = cmd_c;
	assign link.rd_valid  = (state_q == SEND_RD);
	assign link.rd_addr   = 24'h000000; // any address reads the overlay
	assign poll_busy      = (state_q != IDLE);
	assign poll_done      = done_q;
	assign status_out     = stat_q;

endmodule

/* flash_link_sva.sv */
// concurrent checks on the host to device status link
`timescale 1ns/1ns
module flash_link_sva
	import status_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              resetn,
	input wire logic              cmd_valid,
	input wire logic [CMD_W-1:0]  cmd_code,
	input wire logic              rd_valid,
	input wire logic [ADDR_W-1:0] rd_addr,
	input wire logic              rd_done,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic              rd_was_status
);
	// ****************************************
	// overlay tracking
	// ****************************************
	logic armed_q;
	logic armed_d;

	// a read in the command cycle still hits the array, so the command wins
	always_comb begin
		armed_d = armed_q;
		if (cmd_valid && cmd_code == CMD_STATUS_READ) begin
			armed_d = 1'b1;
		end else if (rd_valid) begin
			armed_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= armed_d;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// ****************************************
	// properties
	// ****************************************
	a_read_answer_time: assert property (rd_valid |=> rd_done)
		else $error("read not answered next cycle");
	a_done_has_cause: assert property (rd_done |-> $past(rd_valid))
		else $error("read answer without a read");
	a_status_next_read: assert property ((cmd_valid && cmd_code == CMD_STATUS_READ)
		##1 rd_valid |=> rd_was_status)
		else $error("read after status command missed the overlay");
	a_overlay_one_read: assert property (rd_done |-> rd_was_status == $past(armed_q))
		else $error("overlay applied to the wrong read");
	a_data_holds: assert property (!rd_done |-> $stable(rd_data))
		else $error("read data moved without a read");
	a_read_alone: assert property (rd_valid |-> !cmd_valid)
		else $error("host mixed read and command");
	a_cmd_known: assert property (cmd_valid |->
		cmd_code inside {CMD_STATUS_READ, CMD_CLEAR_STATUS})
		else $error("host sent an unexpected command");
	a_poll_again: assert property (rd_done && rd_was_status && !rd_data[BIT_READY]
		|-> ##[1:3] (cmd_valid && cmd_code == CMD_STATUS_READ))
		else $error("host stopped polling while busy");
endmodule

/* flash_algorithm_status_register_tb_top.sv */
// testbench: host and device ends joined, plus a bench-driven device
`timescale 1ns/1ns
module flash_algorithm_status_register_tb_top
	import status_pkg::*;
;
	logic        clk_sys;
	logic        resetn;
	logic [14:0] ev;
	logic        poll_start;
	logic        clear_req;
	logic        poll_busy;
	logic        poll_done;
	logic        done_seen;
	logic [15:0] array_data;
	logic [15:0] status_now;
	logic [15:0] status_b;
	logic [15:0] status_out;
	logic        soft_b;
	int          miscompares;
	int          num_checks;

	flash_link_if la();
	flash_link_if lb();

	// ****************************************
	// ends under test
	// ****************************************
	// both devices see the same algorithm events; only lb is bench driven
	flash_status_device flash_status_device_inst (.clk_sys, .resetn, .link(la),
		.alg_start(ev[0]), .alg_done(ev[1]), .erase_done(ev[2]), .erase_failed(ev[3]),
		.prog_done(ev[4]), .prog_failed(ev[5]), .prog_to_susp_sector(ev[6]),
		.buf_abort(ev[7]), .lock_hit(ev[8]), .check_done(ev[9]), .check_ok(ev[10]),
		.erase_suspend(ev[11]), .prog_suspend(ev[12]), .crc_suspend(ev[13]),
		.crc_resume(ev[14]), .array_data, .status_now, .soft_reset_pulse());
	flash_status_device flash_status_device_b_inst (.clk_sys, .resetn, .link(lb),
		.alg_start(ev[0]), .alg_done(ev[1]), .erase_done(ev[2]), .erase_failed(ev[3]),
		.prog_done(ev[4]), .prog_failed(ev[5]), .prog_to_susp_sector(ev[6]),
		.buf_abort(ev[7]), .lock_hit(ev[8]), .check_done(ev[9]), .check_ok(ev[10]),
		.erase_suspend(ev[11]), .prog_suspend(ev[12]), .crc_suspend(ev[13]),
		.crc_resume(ev[14]), .array_data, .status_now(status_b), .soft_reset_pulse(soft_b));
	flash_status_host flash_status_host_inst (.clk_sys, .resetn, .link(la), .poll_start,
		.clear_req, .poll_busy, .poll_done, .status_out);
	flash_link_sva flash_link_sva_inst (.clk_sys, .resetn, .cmd_valid(la.cmd_valid),
		.cmd_code(la.cmd_code), .rd_valid(la.rd_valid), .rd_addr(la.rd_addr),
		.rd_done(la.rd_done), .rd_data(la.rd_data), .rd_was_status(la.rd_was_status));

	always #10 clk_sys = ~clk_sys;

	// poll_done is a one-cycle pulse, so keep it sticky for the waiting task;
	// reset or a new poll request rearms it, from this one process only
	always @(posedge clk_sys) begin
		if (resetn !== 1'b1 || poll_start === 1'b1) begin
			done_seen <= 1'b0;
		end else if (poll_done === 1'b1) begin
			done_seen <= 1'b1;
		end
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic fire(input logic [14:0] v);
		@(posedge clk_sys) ev <= v;
		@(posedge clk_sys) ev <= '0;
		@(negedge clk_sys);
	endtask

	task automatic bcmd(input cmd_e c);
		@(posedge clk_sys);
		lb.cmd_valid <= 1'b1;
		lb.cmd_code  <= c;
		@(posedge clk_sys) lb.cmd_valid <= 1'b0;
		@(negedge clk_sys);
	endtask

	task automatic brd();
		@(posedge clk_sys);
		lb.rd_valid <= 1'b1;
		lb.rd_addr  <= ~lb.rd_addr;
		@(posedge clk_sys) lb.rd_valid <= 1'b0;
		@(negedge clk_sys);
	endtask

	task automatic poll_go();
		@(posedge clk_sys);
		poll_start <= 1'b1;
		@(posedge clk_sys) poll_start <= 1'b0;
		@(negedge clk_sys);
	endtask

	task automatic poll_wait();
		for (int n = 0; n < 200 && done_seen !== 1'b1; n++) @(negedge clk_sys);
		chk({15'h0, done_seen}, 16'h0001);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic s_results();
		chk(status_now & ~RESERVED_MASK, STATUS_RESET);
		fire(15'h000c);
		chk(status_now & ~RESERVED_MASK, 16'h00a0);
		fire(15'h0130);
		chk(status_now & ~RESERVED_MASK, 16'h00b2);
		fire(15'h0080);
		chk(status_now & ~RESERVED_MASK, 16'h00ba);
		fire(15'h0600);
		chk(status_now & ~RESERVED_MASK, 16'h00bb);
		poll_go();
		poll_wait();
		chk(status_out, 16'h00bb);
		@(posedge clk_sys) clear_req <= 1'b1;
		@(posedge clk_sys) clear_req <= 1'b0;
		@(negedge clk_sys);
		chk(status_now & ~RESERVED_MASK, 16'h0080);
	endtask

	task automatic s_busy();
		fire(15'h0081);
		chk(status_now & 16'h0080, 16'h0000);
		poll_go();
		repeat (20) @(negedge clk_sys);
		chk({15'h0, poll_busy}, 16'h0001);
		chk(status_out, 16'h0000);
		fire(15'h0002);
		poll_wait();
		chk(status_out, 16'h0088);
	endtask

	task automatic s_suspend();
		bcmd(CMD_CLEAR_STATUS);
		fire(15'h0800);
		chk(status_b & ~RESERVED_MASK, 16'h00c0);
		fire(15'h0050);
		fire(15'h0004);
		chk(status_b & ~RESERVED_MASK, 16'h00f0);
		bcmd(CMD_ERASE_RESUME);
		chk(status_b & ~RESERVED_MASK, 16'h00b0);
		bcmd(CMD_CLEAR_STATUS);
		fire(15'h1000);
		fire(15'h0010);
		fire(15'h0004);
		chk(status_b & ~RESERVED_MASK, 16'h00b4);
		bcmd(CMD_PROG_RESUME);
		chk(status_b & ~RESERVED_MASK, 16'h00b0);
		fire(15'h2000);
		chk(status_b & ~RESERVED_MASK, 16'h01b0);
		fire(15'h4000);
		bcmd(CMD_SOFT_RESET);
		chk({15'h0, soft_b}, 16'h0001);
		chk(status_b & ~RESERVED_MASK, 16'h0080);
	endtask

	task automatic s_overlay();
		bcmd(CMD_STATUS_READ);
		brd();
		chk(lb.rd_data & ~RESERVED_MASK, 16'h0080);
		chk({15'h0, lb.rd_was_status}, 16'h0001);
		brd();
		chk(lb.rd_data, array_data);
		chk({15'h0, lb.rd_was_status}, 16'h0000);
	endtask

	// warm reset in mid-run, then an overlay read straight after release
	task automatic s_warm_reset();
		fire(15'h0880);
		chk(status_b & ~RESERVED_MASK, 16'h00c8);
		@(posedge clk_sys) resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(status_now & ~RESERVED_MASK, STATUS_RESET);
		chk(status_b & ~RESERVED_MASK, STATUS_RESET);
		chk(lb.rd_data, 16'h0000);
		@(posedge clk_sys) resetn <= 1'b1;
		@(negedge clk_sys);
		bcmd(CMD_STATUS_READ);
		brd();
		chk(lb.rd_data & ~RESERVED_MASK, STATUS_RESET);
	endtask

	task automatic stop_test();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		clk_sys      = 1'b0;
		resetn       = 1'b0;
		ev           = '0;
		poll_start   = 1'b0;
		clear_req    = 1'b0;
		array_data   = 16'h5a5a;
		lb.cmd_valid = 1'b0;
		lb.cmd_code  = CMD_NONE;
		lb.rd_valid  = 1'b0;
		lb.rd_addr   = 24'h00a5c3;
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		@(negedge clk_sys);
		s_results();
		s_busy();
		s_suspend();
		s_overlay();
		s_warm_reset();
		stop_test();
	end

	// the whole run needs well under two thousand cycles
	initial begin
		#200000;
		miscompares++;
		stop_test();
	end
endmodule
